// file: hw/pepf_framer.sv
/*
 * progress event packet framer: emits the first-sync and asteroid-start
 * event reports as an 18 byte stream with valid/ready handshake.
 * assumes the receiver holds tx_ready as it likes; time inputs come from
 * logic on the same clock, the time sync pulse arrives from a pin.
 */
`timescale 1ns/10ps
module pepf_framer #(
    parameter logic [7:0] SUBTYPE = pepf_pkg::SVC_SUBTYPE
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // start-up and event sources
    input  wire logic        startup_ok,
    input  wire logic        time_sync_cmd,
    input  wire logic        time_sync_pulse,
    input  wire logic        asteroid_start,
    input  wire logic [47:0] time_now,
    input  wire logic [47:0] asteroid_start_time,
    // byte stream to the telemetry receiver
    output logic       [7:0] tx_data,
    output logic             tx_valid,
    output logic             tx_last,
    input  wire logic        tx_ready,
    // status
    output logic             sync_locked
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_BUILD, ST_SEND}
        pepf_state_e;

    pepf_state_e                     state_r;
    pepf_state_e                     state_nxt;
    logic                            ts_s1_r;
    logic                            ts_s2_r;
    logic                            ts_s3_r;
    logic                            ts_flt_r;
    logic                            cmd_seen_r;
    logic                            pulse_seen_r;
    logic                            locked_r;
    logic                            pend_sync_r;
    logic                            pend_ast_r;
    logic [pepf_pkg::TIME_W-1:0]     sync_time_r;
    logic [pepf_pkg::TIME_W-1:0]     ast_time_r;
    logic                            sel_ast_r;
    logic [pepf_pkg::PKT_W-1:0]      pkt_r;
    logic [pepf_pkg::IDX_W-1:0]      idx_r;
    logic                            valid_r;

    pepf_seq_if #(.SID_W(pepf_pkg::SID_W), .SEQ_W(pepf_pkg::SEQ_W)) seq ();

    pepf_seq_store #(
        .N_STREAMS (pepf_pkg::N_STREAMS),
        .SID_W     (pepf_pkg::SID_W),
        .SEQ_W     (pepf_pkg::SEQ_W)
    ) u_store (
        .clock (clock),
        .rst_b (rst_b),
        .seq   (seq.store)
    );

    // pulse filter: a change counts once stages two and three agree
    wire ts_stable = (ts_s2_r == ts_s3_r);
    wire ts_rise   = ts_stable && ts_s3_r && !ts_flt_r;
    wire lock_now  = !locked_r && startup_ok
                     && (cmd_seen_r || time_sync_cmd)
                     && (pulse_seen_r || ts_rise);
    wire take      = (state_r == ST_IDLE) && (pend_sync_r || pend_ast_r);
    wire take_ast  = !pend_sync_r;
    wire accept    = valid_r && tx_ready;
    wire last_byte = (idx_r == pepf_pkg::LAST_IDX);
    wire done      = accept && last_byte;
    wire build     = (state_r == ST_BUILD);

    wire [15:0] len_field = pepf_pkg::SRC_BYTES + pepf_pkg::LEN_ADD;
    wire [15:0] eid = sel_ast_r ? pepf_pkg::EID_AST_START
                                : pepf_pkg::EID_FIRST_SYNC;
    wire [47:0] stamp = sel_ast_r ? ast_time_r : sync_time_r;
    wire [pepf_pkg::PKT_W-1:0] pkt_img = {
        pepf_pkg::VERSION, pepf_pkg::PKT_TYPE_TM,
        pepf_pkg::SEC_HDR_FLAG,
        pepf_pkg::APID, pepf_pkg::CATEGORY, pepf_pkg::SEG_FLAGS,
        seq.rd_count,
        len_field,
        stamp,
        pepf_pkg::SVC_VERSION, pepf_pkg::CKSUM_FLAG,
        pepf_pkg::SPARE,
        pepf_pkg::SVC_TYPE,
        SUBTYPE,
        pepf_pkg::PAD_BYTE,
        eid};

    assign seq.rd_en    = take;
    assign seq.rd_sid   = pepf_pkg::SID_EVENT;
    assign seq.wr_en    = build;
    assign seq.wr_sid   = pepf_pkg::SID_EVENT;
    assign seq.wr_count = seq.rd_count + pepf_pkg::SEQ_STEP;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_FETCH: begin
                state_nxt = ST_BUILD;
            end
            ST_BUILD: begin
                state_nxt = ST_SEND;
            end
            ST_SEND: begin
                if (done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ts_s1_r  <= 1'b0;
            ts_s2_r  <= 1'b0;
            ts_s3_r  <= 1'b0;
            ts_flt_r <= 1'b0;
        end else begin
            ts_s1_r <= time_sync_pulse;
            ts_s2_r <= ts_s1_r;
            ts_s3_r <= ts_s2_r;
            if (ts_stable) begin
                ts_flt_r <= ts_s3_r;
            end
        end
    end

    // sync evidence gathers until the one and only lock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_seen_r   <= 1'b0;
            pulse_seen_r <= 1'b0;
            locked_r     <= 1'b0;
            sync_time_r  <= '0;
        end else begin
            cmd_seen_r   <= cmd_seen_r || time_sync_cmd;
            pulse_seen_r <= pulse_seen_r || ts_rise;
            if (lock_now) begin
                locked_r    <= 1'b1;
                sync_time_r <= time_now;
            end
        end
    end

    // a new event in the cycle its flag is taken stays pending
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pend_sync_r <= 1'b0;
            pend_ast_r  <= 1'b0;
            ast_time_r  <= '0;
            sel_ast_r   <= 1'b0;
        end else begin
            if (lock_now) begin
                pend_sync_r <= 1'b1;
            end else if (take && !take_ast) begin
                pend_sync_r <= 1'b0;
            end
            if (asteroid_start) begin
                pend_ast_r <= 1'b1;
                ast_time_r <= asteroid_start_time;
            end else if (take && take_ast) begin
                pend_ast_r <= 1'b0;
            end
            if (take) begin
                sel_ast_r <= take_ast;
            end
        end
    end

    // stream runs msb first; a stalled byte is held until accepted
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            pkt_r   <= '0;
            idx_r   <= pepf_pkg::IDX_ZERO;
            valid_r <= 1'b0;
            tx_last <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (build) begin
                pkt_r   <= pkt_img;
                idx_r   <= pepf_pkg::IDX_ZERO;
                valid_r <= 1'b1;
                tx_last <= 1'b0;
            end else if (accept) begin
                pkt_r   <= {pkt_r[pepf_pkg::PKT_W-9:0], 8'h00};
                idx_r   <= idx_r + pepf_pkg::IDX_STEP;
                valid_r <= !last_byte;
                tx_last <= (idx_r + pepf_pkg::IDX_STEP) == pepf_pkg::LAST_IDX;
            end
        end
    end

    assign tx_data     = pkt_r[pepf_pkg::PKT_W-1 -: 8];
    assign tx_valid    = valid_r;
    assign sync_locked = locked_r;
endmodule

// file: hw/pepf_pkg.sv
/*
 * constants of the progress event packet framer: header fields, event ids,
 * packet geometry and sequence counter store sizes.
 * assumes nothing of its surroundings.
 */
package pepf_pkg;
    // primary header
    localparam logic [2:0]  VERSION      = 3'h0;
    localparam logic        PKT_TYPE_TM  = 1'h0;
    localparam logic        SEC_HDR_FLAG = 1'h1;
    localparam logic [6:0]  APID         = 7'h47;
    localparam logic [3:0]  CATEGORY     = 4'h7;
    localparam logic [1:0]  SEG_FLAGS    = 2'h3;
    localparam int          SEQ_W        = 14;
    localparam logic [13:0] SEQ_RESET    = 14'h0000;
    localparam logic [13:0] SEQ_STEP     = 14'h0001;
    localparam logic [15:0] LEN_ADD      = 16'h0009;
    localparam logic [15:0] SRC_BYTES    = 16'h0002;
    localparam int          TIME_W       = 48;
    // secondary header
    localparam logic [2:0]  SVC_VERSION  = 3'h2;
    localparam logic        CKSUM_FLAG   = 1'h0;
    localparam logic [3:0]  SPARE        = 4'h0;
    localparam logic [7:0]  SVC_TYPE     = 8'h05;
    localparam logic [7:0]  SVC_SUBTYPE  = 8'h03;
    localparam logic [7:0]  PAD_BYTE     = 8'h00;
    // source data
    localparam logic [15:0] EID_FIRST_SYNC = 16'ha7fe;
    localparam logic [15:0] EID_AST_START  = 16'ha7ff;
    // geometry
    localparam int          PKT_BYTES    = 18;
    localparam int          PKT_W        = PKT_BYTES * 8;
    localparam int          IDX_W        = 5;
    localparam logic [4:0]  LAST_IDX     = 5'h11;
    localparam logic [4:0]  IDX_ZERO     = 5'h00;
    localparam logic [4:0]  IDX_STEP     = 5'h01;
    // sequence counter store
    localparam int          N_STREAMS    = 4;
    localparam int          SID_W        = 2;
    localparam logic [1:0]  SID_EVENT    = 2'h0;
endpackage

// file: hw/pepf_seq_if.sv
/*
 * carrier between the framer and its sequence counter store.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface pepf_seq_if #(
    parameter int SID_W = 2,
    parameter int SEQ_W = 14
);
    logic [SID_W-1:0] rd_sid;
    logic             rd_en;
    logic [SEQ_W-1:0] rd_count;
    logic             wr_en;
    logic [SID_W-1:0] wr_sid;
    logic [SEQ_W-1:0] wr_count;

    modport framer (output rd_sid, output rd_en, input rd_count,
                    output wr_en, output wr_sid, output wr_count);
    modport store  (input rd_sid, input rd_en, output rd_count,
                    input wr_en, input wr_sid, input wr_count);
endinterface

// file: hw/pepf_seq_store.sv
/*
 * one sequence counter per apid/category stream, read data registered.
 * assumes the caller writes back the incremented count itself.
 */
`timescale 1ns/10ps
module pepf_seq_store #(
    parameter int N_STREAMS = pepf_pkg::N_STREAMS,
    parameter int SID_W     = pepf_pkg::SID_W,
    parameter int SEQ_W     = pepf_pkg::SEQ_W
) (
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst_b,
    // framer side
    pepf_seq_if.store   seq
);
    logic [SEQ_W-1:0] count_r [N_STREAMS];

    generate
        if (N_STREAMS < 1 || N_STREAMS > (1 << SID_W)) begin : g_chk
            $error("pepf_seq_store: N_STREAMS does not fit SID_W");
        end
    endgenerate

    // every stream starts from zero after reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < N_STREAMS; i++) begin
                count_r[i] <= '0;
            end
        end else if (seq.wr_en) begin
            count_r[seq.wr_sid] <= seq.wr_count;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            seq.rd_count <= '0;
        end else if (seq.rd_en) begin
            seq.rd_count <= count_r[seq.rd_sid];
        end
    end
endmodule

// file: test/pepf_framer_asserts.sv
/* checker of the framer byte stream and lock flag.
   assumes it is bound into pepf_framer and sees its ports only. */
`timescale 1ns/10ps
module pepf_framer_asserts (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_b,
    // watched ports
    input wire logic       startup_ok,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_last,
    input wire logic       tx_ready,
    input wire logic       sync_locked
);
    logic [4:0] idx_r;
    // byte position of the byte on offer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            idx_r <= 5'h00;
        end else if (tx_valid && tx_ready) begin
            idx_r <= tx_last ? 5'h00 : idx_r + 5'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    first_byte_a: assert property (
        $rose(tx_valid) |-> tx_data == 8'h0c)
        else $error("bad first byte");
    ids_byte_a: assert property (
        tx_valid && idx_r == 5'h01 |-> tx_data == 8'h77)
        else $error("bad id byte");
    pkt_len_a: assert property (
        tx_valid && idx_r == 5'h05 |-> tx_data == 8'h0b)
        else $error("bad length");
    svc_ver_a: assert property (
        tx_valid && idx_r == 5'h0c |-> tx_data == 8'h40)
        else $error("bad service version");
    svc_type_a: assert property (
        tx_valid && idx_r == 5'h0d |-> tx_data == 8'h05)
        else $error("bad service type");
    sub_type_a: assert property (
        tx_valid && idx_r == 5'h0e |-> tx_data == 8'h03)
        else $error("bad subtype");
    eid_high_a: assert property (
        tx_valid && idx_r == 5'h10 |-> tx_data == 8'ha7)
        else $error("bad event id high byte");
    last_byte_a: assert property (
        tx_valid |-> tx_last == (idx_r == 5'h11))
        else $error("last flag misplaced");
    stall_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte changed in stall");
    pkt_gap_a: assert property (
        tx_valid && tx_ready && tx_last |=> !tx_valid [*3])
        else $error("no idle gap");
    lock_keep_a: assert property (
        sync_locked |=> sync_locked)
        else $error("lock dropped");
    lock_cause_a: assert property (
        $rose(sync_locked) |-> $past(startup_ok))
        else $error("lock without start-up");
endmodule

// file: test/pepf_rx_model.sv
/* telemetry receiver model: takes framer bytes, may stall.
   assumes a valid/ready byte handshake on one clock. */
`timescale 1ns/10ps
module pepf_rx_model (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_b,
    // byte stream
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_last,
    output logic           tx_ready,
    // bench control
    input wire logic       slow
);
    logic [2:0] ph_r;
    logic [8:0] got_q[$];
    // slow mode stalls two cycles in five so holds get exercised
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ph_r <= 3'h0;
            tx_ready <= 1'b0;
        end else begin
            ph_r <= (ph_r == 3'h4) ? 3'h0 : ph_r + 3'h1;
            tx_ready <= !slow || (ph_r < 3'h3);
            if (tx_valid && tx_ready) got_q.push_back({tx_last, tx_data});
        end
    end
endmodule

// file: test/tb_top.sv
/* bench of the progress event framer with a receiver model.
   assumes the framer and receiver share one 40 MHz clock. */
`timescale 1ns/10ps
module tb_top;
    logic        clock, rst_b, startup_ok, time_sync_cmd, time_sync_pulse;
    logic        asteroid_start, tx_valid, tx_last, tx_ready, sync_locked;
    logic        slow;
    logic [47:0] time_now, asteroid_start_time;
    logic [7:0]  tx_data;
    int          err_count, n_tests;
    pepf_framer i_pepf_framer (.clock(clock), .rst_b(rst_b),
        .startup_ok(startup_ok), .time_sync_cmd(time_sync_cmd),
        .time_sync_pulse(time_sync_pulse), .asteroid_start(asteroid_start),
        .time_now(time_now), .asteroid_start_time(asteroid_start_time),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .sync_locked(sync_locked));
    pepf_rx_model i_pepf_rx_model (.clock(clock), .rst_b(rst_b),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .slow(slow));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic get_pkt(input logic [13:0] seq, input logic [47:0] tm,
                           input logic [15:0] eid);
        logic [143:0] exp;
        logic [143:0] got;
        logic [8:0]   b;
        int           n;
        exp = {8'h0c, 8'h77, 2'h3, seq, 16'h000b, tm, 8'h40, 8'h05, 8'h03,
               8'h00, eid};
        got = '0;
        n = 0;
        while (i_pepf_rx_model.got_q.size() < 18 && n < 600) begin
            @(posedge clock);
            n++;
        end
        if (i_pepf_rx_model.got_q.size() < 18) begin
            err_count++;
            complete_run();
        end
        for (int i = 0; i < 18; i++) begin
            b = i_pepf_rx_model.got_q.pop_front();
            got[143-8*i -: 8] = b[7:0];
            chk(b[8], i == 17);
        end
        chk(got[143:128], exp[143:128]);
        chk(got[127:112], exp[127:112]);
        chk(got[111:96], exp[111:96]);
        chk(got[95:48], exp[95:48]);
        chk(got[47:32], exp[47:32]);
        chk(got[31:16], exp[31:16]);
        chk(got[15:0], exp[15:0]);
    endtask
    task automatic sync_evt();
        @(posedge clock);
        time_sync_cmd <= 1'b1;
        time_sync_pulse <= 1'b1;
        @(posedge clock);
        time_sync_cmd <= 1'b0;
        repeat (6) @(posedge clock);
        time_sync_pulse <= 1'b0;
    endtask
    task automatic ast_evt(input logic [47:0] tm);
        @(posedge clock);
        asteroid_start <= 1'b1;
        asteroid_start_time <= tm;
        @(posedge clock);
        asteroid_start <= 1'b0;
    endtask
    task automatic t_gate();
        time_now <= 48'h1234_5678_9abc;
        sync_evt();
        repeat (30) @(posedge clock);
        chk(sync_locked, 1'b0);
        chk(i_pepf_rx_model.got_q.size(), 0);
        startup_ok <= 1'b1;
        get_pkt(14'h0000, 48'h1234_5678_9abc, 16'ha7fe);
        chk(sync_locked, 1'b1);
    endtask
    task automatic t_aster();
        slow <= 1'b1;
        time_now <= 48'hffff_0000_ffff;
        ast_evt(48'h0fed_cba9_8765);
        repeat (10) @(posedge clock);
        ast_evt(48'h0102_0304_0506);
        // a second sync must not bring another first-sync report
        sync_evt();
        get_pkt(14'h0001, 48'h0fed_cba9_8765, 16'ha7ff);
        get_pkt(14'h0002, 48'h0102_0304_0506, 16'ha7ff);
        repeat (80) @(posedge clock);
        chk(i_pepf_rx_model.got_q.size(), 0);
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        err_count = 0;
        n_tests = 0;
        rst_b = 1'b0;
        {startup_ok, time_sync_cmd, time_sync_pulse, asteroid_start} = 4'h0;
        time_now = 48'h0;
        asteroid_start_time = 48'h0;
        slow = 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        chk(tx_valid, 1'b0);
        chk(tx_data, 8'h00);
        t_gate();
        t_aster();
        complete_run();
    end
endmodule
bind pepf_framer pepf_framer_asserts i_pepf_framer_asserts (
    .clock(clock), .rst_b(rst_b), .startup_ok(startup_ok),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .sync_locked(sync_locked));
